// *** efca_egress_fc.sv ***
/*
  Egress flow control and frame aging for one port: PAUSE and priority
  PAUSE frame requests, receive-pause transmit halt, half-duplex
  backpressure and discard of aged frames.
  Assumes synchronous inputs, a frame builder behind the valid/ready
  request port, and a buffer that drops its head frame on the discard pulse.
*/
`timescale 1ns/1ps
module efca_egress_fc (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire efca_pkg::efca_cfg_type cfg_i,
  input wire logic [efca_pkg::LEVEL_W-1:0] used_level_i,
  input wire logic analyzer_fc_req_i,
  input wire logic [efca_pkg::PRIO_N-1:0] pfc_req_i,
  input wire logic rx_pause_valid_i,
  input wire logic [efca_pkg::PAUSE_W-1:0] rx_pause_time_i,
  input wire logic ctrl_frame_ready_i,
  output logic ctrl_frame_valid_o,
  output efca_pkg::efca_ctrl_frame_type ctrl_frame_o,
  output logic tx_halt_o,
  output logic hdx_collide_o,
  input wire logic head_valid_i,
  input wire logic head_era_aged_i,
  input wire logic head_done_i,
  output logic frame_discard_o,
  output logic [efca_pkg::CNT_W-1:0] aged_frame_counter_o
);
  import efca_pkg::*;

  efca_state_type st_q;
  efca_state_type st_d;
  logic tick;
  logic fc_req;
  logic pause_mode;
  logic pause_load;
  logic pfc_load;
  logic age_hit;
  logic [PAUSE_W-1:0] half_time;

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly shared by PAUSE and priority PAUSE requests
  function automatic efca_ctrl_frame_type build_frame(
    input logic pfc,
    input logic [PRIO_N-1:0] mask,
    input logic [PAUSE_W-1:0] ptime,
    input logic [ADDR_HALF_W-1:0] upper,
    input logic [ADDR_HALF_W-1:0] lower
  );
    efca_ctrl_frame_type f;
    f.dmac = PAUSE_DMAC;
    f.smac = {upper, lower};
    f.pfc = pfc;
    f.prio_mask = mask;
    f.pause_time = ptime;
    return f;
  endfunction

  efca_quanta_tick u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .speed_i(cfg_i.speed),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_d = st_q;
    pause_load = 1'b0;
    pfc_load = 1'b0;
    age_hit = 1'b0;
    st_d.discard = 1'b0;
    half_time = {1'b0, cfg_i.generated_pause_time[PAUSE_W-1:1]};
    pause_mode = !cfg_i.priority_fc_enable && !cfg_i.half_duplex_backpressure_enable;
    fc_req = (cfg_i.analyzer_fc_request_enable && analyzer_fc_req_i)
          || (cfg_i.queue_fc_request_enable && st_q.wm_fc);

    // Hysteresis on the used-resource level
    if (used_level_i > cfg_i.high_wm) begin
      st_d.wm_fc = 1'b1;
    end else if (used_level_i < cfg_i.low_wm) begin
      st_d.wm_fc = 1'b0;
    end

    // Request port: one frame at a time, held until accepted
    if (st_q.frame_valid && ctrl_frame_ready_i) begin
      st_d.frame_valid = 1'b0;
    end

    // Regular PAUSE generation
    if (tick && st_q.refresh_cnt != QUANTA_MAX) begin
      st_d.refresh_cnt = st_q.refresh_cnt + 16'h0001;
    end
    if (!pause_mode) begin
      st_d.fc_state = FC_IDLE;
      st_d.refresh_cnt = PAUSE_ZERO;
    end else begin
      unique case (st_q.fc_state)
        FC_IDLE: begin
          if (fc_req && !st_q.frame_valid) begin
            pause_load = 1'b1;
            st_d.fc_state = FC_HOLD;
          end
        end
        FC_HOLD: begin
          if (!fc_req) begin
            // Without the option the partner simply times out
            st_d.fc_state = cfg_i.zero_pause_on_release ? FC_RELEASE : FC_IDLE;
          end else if (st_q.refresh_cnt >= half_time && !st_q.frame_valid) begin
            pause_load = 1'b1;
          end
        end
        FC_RELEASE: begin
          if (!st_q.frame_valid) begin
            st_d.frame_valid = 1'b1;
            st_d.frame = build_frame(1'b0, '0, PAUSE_ZERO,
                                     cfg_i.control_source_addr_upper,
                                     cfg_i.control_source_addr_lower);
            st_d.fc_state = FC_IDLE;
          end
        end
        // Unused code: fall back to idle rather than hang
        default: st_d.fc_state = FC_IDLE;
      endcase
    end
    if (pause_load) begin
      st_d.frame_valid = 1'b1;
      st_d.frame = build_frame(1'b0, '0, cfg_i.generated_pause_time,
                               cfg_i.control_source_addr_upper,
                               cfg_i.control_source_addr_lower);
      st_d.refresh_cnt = PAUSE_ZERO;
    end

    // Priority PAUSE generation with minimum spacing
    if (tick && st_q.space_cnt != PAUSE_ZERO) begin
      st_d.space_cnt = st_q.space_cnt - 16'h0001;
    end
    if (!cfg_i.priority_fc_enable) begin
      st_d.pfc_sent = '0;
      st_d.space_cnt = PAUSE_ZERO;
    end else if (pfc_req_i != st_q.pfc_sent && st_q.space_cnt == PAUSE_ZERO
                 && !st_q.frame_valid) begin
      pfc_load = 1'b1;
      st_d.frame_valid = 1'b1;
      st_d.frame = build_frame(1'b1, pfc_req_i, cfg_i.generated_pause_time,
                               cfg_i.control_source_addr_upper,
                               cfg_i.control_source_addr_lower);
      st_d.pfc_sent = pfc_req_i;
      // An all-released frame skips the gap unless asked for
      if (pfc_req_i != '0 || cfg_i.release_spacing_enable) begin
        st_d.space_cnt = cfg_i.priority_frame_min_spacing;
      end else begin
        st_d.space_cnt = PAUSE_ZERO;
      end
    end

    // Received pause: load on report, count down in quanta
    if (!cfg_i.rx_pause_enable) begin
      st_d.halt_cnt = PAUSE_ZERO;
    end else if (rx_pause_valid_i) begin
      st_d.halt_cnt = rx_pause_time_i;
    end else if (tick && st_q.halt_cnt != PAUSE_ZERO) begin
      st_d.halt_cnt = st_q.halt_cnt - 16'h0001;
    end

    // Aging of the head frame
    if (!head_valid_i || head_done_i || st_q.discard) begin
      st_d.wait_cnt = PAUSE_ZERO;
    end else if (tick && st_q.wait_cnt != QUANTA_MAX) begin
      st_d.wait_cnt = st_q.wait_cnt + 16'h0001;
    end
    // The discard pulse blocks a second hit on the same head frame
    age_hit = cfg_i.frame_aging_enable && head_valid_i && !head_done_i && !st_q.discard
           && (head_era_aged_i
               || st_q.wait_cnt >= cfg_i.aging_limit);
    if (age_hit) begin
      st_d.discard = 1'b1;
      st_d.aged_cnt = st_q.aged_cnt + AGED_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign ctrl_frame_valid_o = st_q.frame_valid;
  assign ctrl_frame_o = st_q.frame;
  assign tx_halt_o = st_q.halt_cnt != PAUSE_ZERO;
  // Port module forces collisions while this is high
  assign hdx_collide_o = cfg_i.half_duplex_backpressure_enable && fc_req;
  assign frame_discard_o = st_q.discard;
  assign aged_frame_counter_o = st_q.aged_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_hyst_rise: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(st_q.wm_fc) |-> $past(used_level_i) > $past(cfg_i.high_wm))
    else $error("watermark request set without exceeding high mark");

  a_hyst_fall: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(st_q.wm_fc) |-> $past(used_level_i) < $past(cfg_i.low_wm))
    else $error("watermark request released above low mark");

  a_analyzer_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    (!cfg_i.analyzer_fc_request_enable && !st_q.wm_fc && st_q.fc_state == FC_IDLE)
    |-> !pause_load)
    else $error("analyzer request passed while disabled");

  a_queue_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    (!cfg_i.queue_fc_request_enable && !analyzer_fc_req_i && st_q.fc_state == FC_IDLE)
    |-> !pause_load)
    else $error("queue watermark request passed while disabled");

  a_pause_refresh: assert property (@(posedge clock_i) disable iff (rst_i)
    pause_load |=> ctrl_frame_valid_o && !ctrl_frame_o.pfc
                   && ctrl_frame_o.pause_time == $past(cfg_i.generated_pause_time)
                   && st_q.refresh_cnt == PAUSE_ZERO)
    else $error("pause frame time or refresh restart wrong");

  a_zero_release: assert property (@(posedge clock_i) disable iff (rst_i)
    (pause_mode && st_q.fc_state == FC_RELEASE && !st_q.frame_valid)
    |=> ctrl_frame_valid_o && ctrl_frame_o.pause_time == PAUSE_ZERO
        && st_q.fc_state == FC_IDLE)
    else $error("zero pause frame not issued on release");

  a_fixed_dmac: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(ctrl_frame_valid_o) |-> ctrl_frame_o.dmac == PAUSE_DMAC)
    else $error("control frame destination address wrong");

  a_smac_join: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(ctrl_frame_valid_o)
    |-> ctrl_frame_o.smac[47:24] == $past(cfg_i.control_source_addr_upper)
        && ctrl_frame_o.smac[23:0] == $past(cfg_i.control_source_addr_lower))
    else $error("control frame source address halves wrong");

  a_rx_halt: assert property (@(posedge clock_i) disable iff (rst_i)
    (cfg_i.rx_pause_enable && rx_pause_valid_i && rx_pause_time_i != PAUSE_ZERO)
    |=> tx_halt_o && st_q.halt_cnt == $past(rx_pause_time_i))
    else $error("received pause did not halt transmit");

  a_pfc_spacing: assert property (@(posedge clock_i) disable iff (rst_i)
    (st_q.space_cnt != PAUSE_ZERO || !cfg_i.priority_fc_enable) |-> !pfc_load)
    else $error("priority frame sent inside minimum spacing");

  a_release_gap: assert property (@(posedge clock_i) disable iff (rst_i)
    (pfc_load && pfc_req_i == '0 && !cfg_i.release_spacing_enable)
    |=> st_q.space_cnt == PAUSE_ZERO)
    else $error("spacing applied after release without option");

  a_hdx_no_pause: assert property (@(posedge clock_i) disable iff (rst_i)
    cfg_i.half_duplex_backpressure_enable |-> !pause_load)
    else $error("pause frame generated in backpressure mode");

  a_era_discard: assert property (@(posedge clock_i) disable iff (rst_i)
    (cfg_i.frame_aging_enable && head_valid_i && head_era_aged_i && !head_done_i
     && !frame_discard_o) |=> frame_discard_o)
    else $error("aging-eligible frame not discarded");

  a_aged_count: assert property (@(posedge clock_i) disable iff (rst_i)
    frame_discard_o |-> aged_frame_counter_o == $past(aged_frame_counter_o) + AGED_ONE)
    else $error("aged frame counter did not advance");

endmodule

// *** efca_pkg.sv ***
/*
  Constants, configuration and state types for the egress flow-control and
  frame-aging block of one switch port.
  Assumes a single 20 MHz core clock and a synchronous active-high reset.
*/
//
// Summary of operation
// - Watermark request sets above high, clears below low
// - Enable gates analyzer policing requests into PAUSE
// - Enable gates queue watermark requests into PAUSE
// - PAUSE carries configured time, refreshed at half
// - Optional zero-time PAUSE when pause cause ends
// - Destination is fixed reserved multicast address
// - Source address joins upper and lower halves
// - Received pause time halts transmit when enabled
// - Priority mode emits frames on queue requests
// - Priority frames spaced by minimum update time
// - Optional spacing also after all-released frame
// - Half duplex uses backpressure, not PAUSE frames
// - Backpressure state goes to port for collisions
// - Aging discards frames stuck for long periods
// - Aging discards frames with aging-eligible era
// - Each aged frame increments a readable counter
package efca_pkg;

  localparam int LEVEL_W = 16;
  localparam int PAUSE_W = 16;
  localparam int PRIO_N = 8;
  localparam int CNT_W = 32;
  localparam int ADDR_HALF_W = 24;

  localparam logic [47:0] PAUSE_DMAC = 48'h0180C2000001;

  // Pause quantum and line rates, tracked in half bit times
  localparam int QUANTUM_BITS = 512;
  localparam int CLOCK_MHZ = 20;
  localparam int RATE_10M_MBPS = 10;
  localparam int RATE_100M_MBPS = 100;
  localparam int RATE_1G_MBPS = 1000;
  localparam int RATE_2G5_MBPS = 2500;
  localparam int ACC_W = 11;
  localparam logic [ACC_W-1:0] QUANTUM_HALF_BITS = ACC_W'(2 * QUANTUM_BITS);
  localparam logic [ACC_W-1:0] INC_10M = ACC_W'(2 * RATE_10M_MBPS / CLOCK_MHZ);
  localparam logic [ACC_W-1:0] INC_100M = ACC_W'(2 * RATE_100M_MBPS / CLOCK_MHZ);
  localparam logic [ACC_W-1:0] INC_1G = ACC_W'(2 * RATE_1G_MBPS / CLOCK_MHZ);
  localparam logic [ACC_W-1:0] INC_2G5 = ACC_W'(2 * RATE_2G5_MBPS / CLOCK_MHZ);

  localparam logic [PAUSE_W-1:0] PAUSE_ZERO = 16'h0000;
  localparam logic [PAUSE_W-1:0] QUANTA_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] AGED_ONE = 32'h00000001;

  typedef enum logic [1:0] {
    SPD_10M = 2'b00,
    SPD_100M = 2'b01,
    SPD_1G = 2'b10,
    SPD_2G5 = 2'b11
  } efca_speed_type;

  // One-bit steps idle -> hold -> release; release -> idle flips both bits
  typedef enum logic [1:0] {
    FC_IDLE = 2'b00,
    FC_HOLD = 2'b01,
    FC_RELEASE = 2'b11
  } efca_fc_state_type;

  typedef struct packed {
    logic analyzer_fc_request_enable;
    logic queue_fc_request_enable;
    logic [PAUSE_W-1:0] generated_pause_time;
    logic zero_pause_on_release;
    logic [ADDR_HALF_W-1:0] control_source_addr_upper;
    logic [ADDR_HALF_W-1:0] control_source_addr_lower;
    logic rx_pause_enable;
    logic priority_fc_enable;
    logic [PAUSE_W-1:0] priority_frame_min_spacing;
    logic release_spacing_enable;
    logic half_duplex_backpressure_enable;
    logic frame_aging_enable;
    logic [PAUSE_W-1:0] aging_limit;
    efca_speed_type speed;
    logic [LEVEL_W-1:0] high_wm;
    logic [LEVEL_W-1:0] low_wm;
  } efca_cfg_type;

  typedef struct packed {
    logic [47:0] dmac;
    logic [47:0] smac;
    logic pfc;
    logic [PRIO_N-1:0] prio_mask;
    logic [PAUSE_W-1:0] pause_time;
  } efca_ctrl_frame_type;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic tick;
  } efca_tick_state_type;

  typedef struct packed {
    efca_fc_state_type fc_state;
    logic wm_fc;
    logic [PAUSE_W-1:0] refresh_cnt;
    logic [PAUSE_W-1:0] halt_cnt;
    logic [PRIO_N-1:0] pfc_sent;
    logic [PAUSE_W-1:0] space_cnt;
    logic frame_valid;
    efca_ctrl_frame_type frame;
    logic [PAUSE_W-1:0] wait_cnt;
    logic discard;
    logic [CNT_W-1:0] aged_cnt;
  } efca_state_type;

  localparam efca_tick_state_type TICK_STATE_RESET = '0;
  localparam efca_state_type STATE_RESET = '0;

endpackage

// *** efca_quanta_tick.sv ***
/*
  Pause-quantum tick generator: one pulse per 512 bit times at line rate.
  Assumes the speed setting is stable except during port reconfiguration.
*/
`timescale 1ns/1ps
module efca_quanta_tick (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire efca_pkg::efca_speed_type speed_i,
  output logic tick_o
);
  import efca_pkg::*;

  efca_tick_state_type st_q;
  efca_tick_state_type st_d;
  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // Fractional accumulator, so 100M, 1G and 2.5G rates stay exact at 20 MHz
  always_comb begin
    st_d = st_q;
    unique case (speed_i)
      SPD_10M: inc = INC_10M;
      SPD_100M: inc = INC_100M;
      SPD_1G: inc = INC_1G;
      SPD_2G5: inc = INC_2G5;
    endcase
    sum = st_q.acc + inc;
    st_d.tick = 1'b0;
    if (sum >= QUANTUM_HALF_BITS) begin
      st_d.acc = sum - QUANTUM_HALF_BITS;
      st_d.tick = 1'b1;
    end else begin
      st_d.acc = sum;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= TICK_STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;

endmodule

// *** efca_frame_sink.sv ***
/*
  Frame builder model standing behind the control frame request port.
  Assumes the request is held, unchanged, until ready is seen high.
*/
`timescale 1ns/1ps
module efca_frame_sink (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic [2:0] wait_q;
  // Slow mode stalls as a busy transmitter would, so held requests get tested
  always_ff @(posedge clock_i) begin
    if (rst_i || !valid_i || ready_o) begin
      wait_q <= 3'h0;
      ready_o <= 1'b0;
    end else begin
      wait_q <= wait_q + 3'h1;
      ready_o <= !slow_i || (wait_q == 3'h4);
    end
  end
endmodule

// *** testbench.sv ***
/*
  Self-checking bench for the egress flow-control and aging block.
  Assumes the frame builder model and one 20 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import efca_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  efca_cfg_type cfg = '0;
  logic [LEVEL_W-1:0] lvl = '0;
  logic [PRIO_N-1:0] pfc = '0;
  logic [PAUSE_W-1:0] rxt = '0;
  logic ana = 1'b0, rxv = 1'b0, slow = 1'b0, hv = 1'b0, era = 1'b0, hd = 1'b0;
  logic ready, valid, halt, coll, disc, vq;
  efca_ctrl_frame_type frm;
  logic [CNT_W-1:0] aged, n_aged;
  int n_fail = 0, checks_done = 0, cyc = 0, rise = 0, gap = 0;
  efca_ctrl_frame_type fq[$];
  logic [CNT_W-1:0] cq[$];

  always #25 clock_i = ~clock_i;

  efca_egress_fc efca_egress_fc_i (.clock_i(clock_i), .rst_i(rst_i), .cfg_i(cfg),
    .used_level_i(lvl), .analyzer_fc_req_i(ana), .pfc_req_i(pfc), .rx_pause_valid_i(rxv),
    .rx_pause_time_i(rxt), .ctrl_frame_ready_i(ready), .ctrl_frame_valid_o(valid),
    .ctrl_frame_o(frm), .tx_halt_o(halt), .hdx_collide_o(coll), .head_valid_i(hv),
    .head_era_aged_i(era), .head_done_i(hd), .frame_discard_o(disc),
    .aged_frame_counter_o(aged));
  efca_frame_sink efca_frame_sink_i (.clock_i(clock_i), .rst_i(rst_i), .valid_i(valid),
    .slow_i(slow), .ready_o(ready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_frame(input efca_ctrl_frame_type e, input efca_ctrl_frame_type s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected frame: expected %h seen %h", e, s);
    end
  endtask

  task automatic chk_word(input string what, input logic [CNT_W-1:0] e,
                          input logic [CNT_W-1:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic s);
    chk_word(what, CNT_W'(e), CNT_W'(s));
  endtask

  function automatic efca_ctrl_frame_type mk(input logic p, input logic [PRIO_N-1:0] m,
                                             input logic [PAUSE_W-1:0] t);
    mk.dmac = 48'h0180C2000001;
    mk.smac = {cfg.control_source_addr_upper, cfg.control_source_addr_lower};
    mk.pfc = p;
    mk.prio_mask = m;
    mk.pause_time = t;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Bounded wait until every noted result has been seen
  task automatic drain(input int n);
    int k;
    k = 0;
    while ((fq.size() != 0 || cq.size() != 0) && k < n) begin
      @(posedge clock_i);
      k++;
    end
    chk_bit("drained", 1'b1, fq.size() == 0 && cq.size() == 0);
  endtask

  // Head frame offered until discarded or 60 cycles pass; k is the wait
  task automatic age(input logic e, input logic d, input logic x, output int k);
    era <= e;
    hd <= d;
    hv <= 1'b1;
    if (x) begin
      n_aged = n_aged + CNT_W'(1);
      cq.push_back(n_aged);
    end
    k = 0;
    while (!disc && k < 60) begin
      @(posedge clock_i);
      k++;
    end
    hv <= 1'b0;
    idle(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    vq <= valid;
    if (valid && !vq) begin
      gap <= cyc - rise;
      rise <= cyc;
    end
    if (!rst_i && valid && ready) begin
      if (fq.size() == 0) chk_bit("spare frame", 1'b0, 1'b1);
      else chk_frame(fq.pop_front(), frm);
    end
    if (!rst_i && disc) begin
      if (cq.size() == 0) chk_bit("spare discard", 1'b0, 1'b1);
      else chk_word("aged count", cq.pop_front(), aged);
    end
  end

  initial begin
    #250000;
    n_fail++;
    final_report();
  end

  initial begin
    int k;
    logic [PRIO_N-1:0] m;
    logic [PAUSE_W-1:0] t;
    void'($urandom(46));
    n_aged = '0;
    @(posedge clock_i);
    cfg.speed <= SPD_2G5;
    cfg.control_source_addr_upper <= 24'($urandom);
    cfg.control_source_addr_lower <= 24'($urandom);
    cfg.high_wm <= 16'h0100;
    cfg.low_wm <= 16'h0080;
    @(posedge clock_i);
    rst_i <= 1'b0;
    idle(2);
    chk_word("aged count", 32'h00000000, aged);
    t = 16'h8000 | 16'($urandom);
    cfg.queue_fc_request_enable <= 1'b1;
    cfg.zero_pause_on_release <= 1'b1;
    cfg.generated_pause_time <= t;
    slow <= 1'b1;
    lvl <= 16'h0100;
    idle(20);
    fq.push_back(mk(1'b0, 8'h00, t));
    lvl <= 16'h0101;
    drain(40);
    lvl <= 16'h0080;
    idle(20);
    fq.push_back(mk(1'b0, 8'h00, 16'h0000));
    lvl <= 16'h007F;
    drain(40);
    $display("test hysteresis done");
    slow <= 1'b0;
    cfg.generated_pause_time <= 16'h0008;
    fq.push_back(mk(1'b0, 8'h00, 16'h0008));
    fq.push_back(mk(1'b0, 8'h00, 16'h0008));
    lvl <= 16'h0101;
    drain(80);
    chk_bit("refresh gap", 1'b1, gap >= 13 && gap <= 24);
    fq.push_back(mk(1'b0, 8'h00, 16'h0000));
    lvl <= 16'h0000;
    drain(40);
    $display("test refresh done");
    cfg.queue_fc_request_enable <= 1'b0;
    cfg.zero_pause_on_release <= 1'b0;
    cfg.generated_pause_time <= t;
    lvl <= 16'h0101;
    ana <= 1'b1;
    idle(40);
    fq.push_back(mk(1'b0, 8'h00, t));
    cfg.analyzer_fc_request_enable <= 1'b1;
    drain(40);
    ana <= 1'b0;
    lvl <= 16'h0000;
    idle(30);
    cfg.half_duplex_backpressure_enable <= 1'b1;
    ana <= 1'b1;
    idle(3);
    chk_bit("collide", 1'b1, coll);
    idle(30);
    ana <= 1'b0;
    idle(2);
    chk_bit("collide", 1'b0, coll);
    cfg.half_duplex_backpressure_enable <= 1'b0;
    $display("test analyzer and backpressure done");
    // Receive pause stays off while priority mode is on
    cfg.rx_pause_enable <= 1'b0;
    cfg.priority_fc_enable <= 1'b1;
    cfg.priority_frame_min_spacing <= 16'h0004;
    cfg.release_spacing_enable <= 1'b1;
    idle(2);
    for (int i = 0; i < 4; i++) begin
      m = (i == 2) ? 8'h00 : 8'($urandom_range(255, 1));
      if (m == pfc && i != 2) m = ~m;
      fq.push_back(mk(1'b1, m, t));
      pfc <= m;
      drain(100);
      if (i > 0) chk_bit("priority spacing", 1'b1, gap >= 13);
    end
    cfg.priority_fc_enable <= 1'b0;
    pfc <= 8'h00;
    idle(10);
    $display("test priority done");
    for (int en = 0; en < 2; en++) begin
      cfg.rx_pause_enable <= en[0];
      @(posedge clock_i);
      rxv <= 1'b1;
      rxt <= 16'h0003;
      @(posedge clock_i);
      rxv <= 1'b0;
      @(posedge clock_i);
      chk_bit("halt", en[0], halt);
      k = 0;
      while (halt && k < 40) begin
        @(posedge clock_i);
        k++;
      end
      if (en == 1) chk_bit("halt length", 1'b1, k >= 6 && k <= 20);
    end
    $display("test receive pause done");
    // Receive pause off so waiting head frames can drain
    cfg.rx_pause_enable <= 1'b0;
    cfg.aging_limit <= 16'h0003;
    age(1'b1, 1'b0, 1'b0, k);
    cfg.frame_aging_enable <= 1'b1;
    age(1'b1, 1'b0, 1'b1, k);
    age(1'b1, 1'b1, 1'b0, k);
    age(1'b0, 1'b0, 1'b1, k);
    chk_bit("stuck wait", 1'b1, k >= 9 && k <= 25);
    drain(10);
    chk_word("aged count", n_aged, aged);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(2);
    chk_word("aged count", 32'h00000000, aged);
    $display("test aging done");
    final_report();
  end
endmodule
